// [design/mps_defs.svh]
// constants for the motor protection supervisor
// How it works
// - asymmetry over 33 percent latches manual-clear fault
// - over-range current beyond 2 s blocks, shows direction
// - drive applied: missing phase or undercurrent messages
// - overload fault clears itself after cool-down
// - reset button also clears a tripped state
// - phases 1 and 3 33 percent apart: off within 2 min
// - 67 percent apart: off within 2 s
// - button held over 6 s enters parameter mode
// - parameter mode blanks lamps 0.3 s every 2 s
// - potentiometer quantized to sixteen steps, shown on lamps
// - next press stores step in non-volatile memory
// - 2 to 6 s press shows stored step 3 s
// - display only when idle and fault-free
// - lamp code binary, supply lamp most significant
// - overload trips, twenty minute cool-down before auto clear
// - overload: manual clear after 2 min, direction flashes
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH

// ************************************************************
// clock and tick
// ************************************************************
`define MPS_CLK_NS      50
`define MPS_TICK_NS     1000000
`define MPS_TICK_CYC    (`MPS_TICK_NS / `MPS_CLK_NS)

// ************************************************************
// times in milliseconds
// ************************************************************
`define MPS_ASYM33_MS   120000
`define MPS_ASYM67_MS   2000
`define MPS_BLOCK_MS    2000
`define MPS_UNDER_MS    2000
`define MPS_COOL_MS     1200000
`define MPS_MANACK_MS   120000
`define MPS_PARAM_MS    6000
`define MPS_SHOW_MS     2000
`define MPS_DISP_MS     3000
`define MPS_BLINK_MS    2000
`define MPS_BLANK_MS    300
`define MPS_FLASH_MS    300

// ************************************************************
// thresholds and field positions
// ************************************************************
`define MPS_PCT_FULL    100
`define MPS_PCT_LO      33
`define MPS_PCT_HI      67
`define MPS_MIN_CUR     8'h10
`define MPS_RATED_LSB   4'hf
`define MPS_POT_MSB     7
`define MPS_POT_LSB     4
`define MPS_FLASH_BIT   8

`endif

// [design/mps_pkg.sv]
// types of the motor protection supervisor
package mps_pkg;
  typedef enum logic [1:0] {
    MPS_NORMAL  = 2'b00,
    MPS_DISPLAY = 2'b01,
    MPS_PARAM   = 2'b11
  } mps_mode_e;

  typedef enum logic [1:0] {
    MPS_F_NONE  = 2'b00,
    MPS_F_ASYM  = 2'b01,
    MPS_F_BLOCK = 2'b11,
    MPS_F_OVLD  = 2'b10
  } mps_fault_e;

  typedef logic [20:0] mps_ms_t;
endpackage : mps_pkg

// [design/mps_tmr_if.sv]
// carrier between the supervisor and one of its interval timers
`timescale 1ns/1ps
interface mps_tmr_if;
  logic tick;
  logic run;
  logic done;
  modport ctl (output tick, output run, input done);
  modport tmr (input tick, input run, output done);
endinterface : mps_tmr_if

// [design/mps_timer.sv]
// millisecond interval timer, restarts whenever run drops
`timescale 1ns/1ps
module mps_timer #(
  parameter int unsigned LIMIT = 1
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // control
  mps_tmr_if.tmr    t
);
  mps_pkg::mps_ms_t cnt_r;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
    end else if (!t.run) begin
      cnt_r <= '0;
    end else if (t.tick && (cnt_r != 21'(LIMIT))) begin
      cnt_r <= cnt_r + 21'h1;
    end
  end

  assign t.done = t.run && (cnt_r == 21'(LIMIT));
endmodule : mps_timer

// [design/mps_top.sv]
// motor protection supervisor: trips, acknowledgement, parameter mode, lamps
`timescale 1ns/1ps
`include "mps_defs.svh"
module mps_top #(
  parameter int unsigned TICK_CYC = `MPS_TICK_CYC
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // front panel and controller pins
  input  wire logic       i_reset_btn,
  input  wire logic       i_drive_ccw,
  input  wire logic       i_drive_cw,
  // measurement front end, same clock
  input  wire logic [7:0] i_cur_l1,
  input  wire logic [7:0] i_cur_l3,
  input  wire logic       i_cur_overrange,
  input  wire logic       i_phase_missing,
  input  wire logic       i_no_motor,
  input  wire logic [7:0] i_pot,
  // non-volatile storage
  input  wire logic [3:0] i_nv_code,
  output logic            o_nv_we,
  output logic [3:0]      o_nv_code,
  // power path and controller status
  output logic            o_motor_ccw,
  output logic            o_motor_cw,
  output logic            o_overload,
  output logic            o_message,
  // lamps
  output logic            o_supply_lamp,
  output logic            o_fault_lamp,
  output logic            o_ccw_lamp,
  output logic            o_cw_lamp
);
  // ************************************************************
  // declarations
  // ************************************************************
  logic [14:0]          div_r;
  logic                 tick_r;
  logic [2:0]           btn_s_r;
  logic [2:0]           ccw_s_r;
  logic [2:0]           cw_s_r;
  logic                 btn_r;
  logic                 btn_prev_r;
  logic                 drv_ccw_r;
  logic                 drv_cw_r;
  logic [12:0]          press_r;
  logic                 btn_rise;
  logic                 btn_fall;
  logic [7:0]           cur_hi;
  logic [7:0]           cur_lo;
  logic [15:0]          diff_pct;
  logic                 asym33;
  logic                 asym67;
  logic                 over_rated;
  logic                 under_cur;
  logic                 drive_any;
  logic                 healthy;
  mps_pkg::mps_fault_e  fault_r;
  logic                 fault_ccw_r;
  mps_pkg::mps_mode_e   mode_r;
  logic                 hold_r;
  logic [3:0]           code_r;
  logic                 init_r;
  logic [8:0]           flash_r;
  logic [10:0]          blink_r;
  logic [8:0]           phase_r;
  logic                 slow;
  logic                 msg_nxt;
  logic [3:0]           lamp_nxt;
  mps_tmr_if t_a33 ();
  mps_tmr_if t_a67 ();
  mps_tmr_if t_blk ();
  mps_tmr_if t_und ();
  mps_tmr_if t_cool ();
  mps_tmr_if t_man ();
  mps_tmr_if t_disp ();
  // ************************************************************
  // millisecond tick
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_r  <= 15'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 15'(TICK_CYC - 1));
      div_r  <= (div_r == 15'(TICK_CYC - 1)) ? 15'h0 : div_r + 15'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) phase_r <= 9'h0;
    else if (tick_r) phase_r <= phase_r + 9'h1;
  end
  assign slow = phase_r[`MPS_FLASH_BIT];
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // debounced button level
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {btn_s_r, ccw_s_r, cw_s_r}               <= 9'h0;
      {btn_r, btn_prev_r, drv_ccw_r, drv_cw_r} <= 4'h0;
    end else begin
      btn_s_r    <= {btn_s_r[1:0], i_reset_btn};
      ccw_s_r    <= {ccw_s_r[1:0], i_drive_ccw};
      cw_s_r     <= {cw_s_r[1:0], i_drive_cw};
      btn_prev_r <= btn_r;
      if (btn_s_r[1] == btn_s_r[2]) btn_r <= btn_s_r[2];
      if (ccw_s_r[1] == ccw_s_r[2]) drv_ccw_r <= ccw_s_r[2];
      if (cw_s_r[1] == cw_s_r[2]) drv_cw_r <= cw_s_r[2];
    end
  end
  assign btn_rise = btn_r && !btn_prev_r;
  assign btn_fall = !btn_r && btn_prev_r;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) press_r <= 13'h0;
    else if (btn_rise) press_r <= 13'h0;
    else if (btn_r && tick_r && (press_r != 13'(`MPS_PARAM_MS))) press_r <= press_r + 13'h1;
  end
  // ************************************************************
  // current evaluation
  // ************************************************************
  assign cur_hi   = (i_cur_l1 > i_cur_l3) ? i_cur_l1 : i_cur_l3;
  assign cur_lo   = (i_cur_l1 > i_cur_l3) ? i_cur_l3 : i_cur_l1;
  assign diff_pct = 16'(cur_hi - cur_lo) * 16'(`MPS_PCT_FULL);
  assign asym33   = (cur_hi != 8'h0) && (diff_pct >= 16'(cur_hi) * 16'(`MPS_PCT_LO));
  assign asym67   = (cur_hi != 8'h0) && (diff_pct >= 16'(cur_hi) * 16'(`MPS_PCT_HI));
  assign over_rated = cur_hi > {code_r, `MPS_RATED_LSB};
  assign under_cur  = (i_cur_l1 < `MPS_MIN_CUR) && (i_cur_l3 < `MPS_MIN_CUR);
  assign drive_any  = drv_ccw_r || drv_cw_r;
  assign healthy    = (fault_r == mps_pkg::MPS_F_NONE);
  // ************************************************************
  // interval timers
  // ************************************************************
  assign t_a33.tick  = tick_r;
  assign t_a67.tick  = tick_r;
  assign t_blk.tick  = tick_r;
  assign t_und.tick  = tick_r;
  assign t_cool.tick = tick_r;
  assign t_man.tick  = tick_r;
  assign t_disp.tick = tick_r;
  assign t_a33.run   = healthy && drive_any && asym33;
  assign t_a67.run   = healthy && drive_any && asym67;
  assign t_blk.run   = healthy && drive_any && i_cur_overrange;
  assign t_und.run   = healthy && drive_any && under_cur;
  assign t_cool.run  = (fault_r == mps_pkg::MPS_F_OVLD);
  assign t_man.run   = (fault_r == mps_pkg::MPS_F_OVLD);
  assign t_disp.run  = (mode_r == mps_pkg::MPS_DISPLAY);
  mps_timer #(.LIMIT(`MPS_ASYM33_MS)) u_a33 (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .t(t_a33.tmr));
  mps_timer #(.LIMIT(`MPS_ASYM67_MS)) u_a67 (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .t(t_a67.tmr));
  mps_timer #(.LIMIT(`MPS_BLOCK_MS))  u_blk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .t(t_blk.tmr));
  mps_timer #(.LIMIT(`MPS_UNDER_MS))  u_und (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .t(t_und.tmr));
  mps_timer #(.LIMIT(`MPS_COOL_MS))   u_cool (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .t(t_cool.tmr));
  mps_timer #(.LIMIT(`MPS_MANACK_MS)) u_man (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .t(t_man.tmr));
  mps_timer #(.LIMIT(`MPS_DISP_MS))   u_disp (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .t(t_disp.tmr));
  // ************************************************************
  // fault state
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault_r     <= mps_pkg::MPS_F_NONE;
      fault_ccw_r <= 1'b0;
    end else begin
      case (fault_r)
        mps_pkg::MPS_F_NONE: begin
          fault_ccw_r <= drv_ccw_r;
          if (t_blk.done) begin
            fault_r <= mps_pkg::MPS_F_BLOCK;
          end else if (t_a67.done) begin
            fault_r <= mps_pkg::MPS_F_ASYM;
          end else if (t_a33.done) begin
            fault_r <= mps_pkg::MPS_F_ASYM;
          end else if (drive_any && over_rated) begin
            fault_r <= mps_pkg::MPS_F_OVLD;
          end
        end
        mps_pkg::MPS_F_OVLD: begin
          if (t_cool.done) begin
            fault_r <= mps_pkg::MPS_F_NONE;
          end else if (btn_rise && t_man.done) begin
            fault_r <= mps_pkg::MPS_F_NONE;
          end
        end
        default: begin
          if (btn_rise) fault_r <= mps_pkg::MPS_F_NONE;
        end
      endcase
    end
  end

  // ************************************************************
  // operating mode
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r  <= mps_pkg::MPS_NORMAL;
      hold_r  <= 1'b0;
      flash_r <= 9'h0;
      blink_r <= 11'h0;
      o_nv_we <= 1'b0;
    end else begin
      o_nv_we <= 1'b0;
      if (tick_r && (flash_r != 9'h0)) flash_r <= flash_r - 9'h1;
      if (mode_r != mps_pkg::MPS_PARAM || flash_r != 9'h0) blink_r <= 11'h0;
      else if (tick_r) blink_r <= (blink_r == 11'(`MPS_BLINK_MS - 1)) ? 11'h0 : blink_r + 11'h1;
      case (mode_r)
        mps_pkg::MPS_NORMAL: begin
          if (btn_r && healthy && (press_r == 13'(`MPS_PARAM_MS))) begin
            mode_r  <= mps_pkg::MPS_PARAM;
            hold_r  <= 1'b1;
            flash_r <= 9'(`MPS_FLASH_MS);
          end else if (btn_fall && healthy && !drive_any && (press_r > 13'(`MPS_SHOW_MS))
                       && (press_r < 13'(`MPS_PARAM_MS))) begin
            mode_r <= mps_pkg::MPS_DISPLAY;
          end
        end
        mps_pkg::MPS_DISPLAY: begin
          if (t_disp.done || drive_any || !healthy) mode_r <= mps_pkg::MPS_NORMAL;
        end
        mps_pkg::MPS_PARAM: begin
          if (hold_r) begin
            hold_r <= !btn_fall;
          end else if (btn_rise) begin
            o_nv_we <= 1'b1;
            mode_r  <= mps_pkg::MPS_NORMAL;
          end
        end
        default: begin
          mode_r <= mps_pkg::MPS_NORMAL;
        end
      endcase
    end
  end

  // ************************************************************
  // stored nominal-current step
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      code_r    <= 4'h0;
      init_r    <= 1'b1;
      o_nv_code <= 4'h0;
    end else begin
      init_r    <= 1'b0;
      o_nv_code <= i_pot[`MPS_POT_MSB:`MPS_POT_LSB];
      if (init_r) code_r <= i_nv_code;
      else if (mode_r == mps_pkg::MPS_PARAM && !hold_r && btn_rise) code_r <= o_nv_code;
    end
  end
  // ************************************************************
  // lamps, power path, status
  // ************************************************************
  always_comb begin
    msg_nxt  = healthy && drive_any && (i_phase_missing || i_no_motor || t_und.done);
    lamp_nxt = {1'b1, 1'b0, drv_ccw_r, drv_cw_r};
    case (mode_r)
      mps_pkg::MPS_PARAM: begin
        if (flash_r != 9'h0) begin
          lamp_nxt = 4'h8;
        end else if (blink_r < 11'(`MPS_BLANK_MS)) begin
          lamp_nxt = 4'h0;
        end else begin
          lamp_nxt = o_nv_code;
        end
      end
      mps_pkg::MPS_DISPLAY: begin
        lamp_nxt = code_r;
      end
      default: begin
        if (!healthy) begin
          lamp_nxt[2] = 1'b1;
          // flash direction when manual clear allowed
          if (fault_r == mps_pkg::MPS_F_OVLD && t_man.done) begin
            lamp_nxt[1:0] = fault_ccw_r ? {slow, 1'b0} : {1'b0, slow};
          end else begin
            lamp_nxt[1:0] = fault_ccw_r ? 2'h2 : 2'h1;
          end
        end else if (msg_nxt) begin
          lamp_nxt[2] = slow;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_motor_ccw   <= 1'b0;
      o_motor_cw    <= 1'b0;
      o_overload    <= 1'b0;
      o_message     <= 1'b0;
      {o_supply_lamp, o_fault_lamp, o_ccw_lamp, o_cw_lamp} <= 4'h0;
    end else begin
      o_motor_ccw   <= healthy && drv_ccw_r && !drv_cw_r;
      o_motor_cw    <= healthy && drv_cw_r && !drv_ccw_r;
      o_overload    <= (fault_r == mps_pkg::MPS_F_OVLD);
      o_message     <= msg_nxt;
      {o_supply_lamp, o_fault_lamp, o_ccw_lamp, o_cw_lamp} <= lamp_nxt;
    end
  end
endmodule : mps_top

// [tb/mps_properties.sv]
// assertion checker for the motor protection supervisor
`timescale 1ns/1ps
module mps_properties #(
  parameter int unsigned TICK_CYC = 1
) (
  // clock, reset and inputs
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire logic       i_drive_ccw,
  input wire logic       i_drive_cw,
  input wire logic [7:0] i_cur_l1,
  input wire logic [7:0] i_cur_l3,
  input wire logic       i_cur_overrange,
  input wire logic       i_no_motor,
  input wire logic [7:0] i_pot,
  // outputs watched
  input wire logic       o_nv_we,
  input wire logic [3:0] o_nv_code,
  input wire logic       o_motor_ccw,
  input wire logic       o_motor_cw,
  input wire logic       o_overload,
  input wire logic       o_message
);
  localparam int unsigned TRIP_LIM = (2000 + 2) * TICK_CYC + 8;
  localparam int unsigned ACK_LIM  = (120000 - 1) * TICK_CYC;
  logic [7:0]  cur_max;
  logic [7:0]  cur_diff;
  logic        one_drive;
  logic        asym_hi;
  logic [31:0] blk_cnt_r;
  logic [31:0] asy_cnt_r;
  logic [31:0] ovl_cnt_r;
  assign cur_max   = (i_cur_l1 > i_cur_l3) ? i_cur_l1 : i_cur_l3;
  assign cur_diff  = (i_cur_l1 > i_cur_l3) ? i_cur_l1 - i_cur_l3 : i_cur_l3 - i_cur_l1;
  assign one_drive = i_drive_cw ^ i_drive_ccw;
  assign asym_hi   = (cur_max != 8'h00) && (16'(cur_diff) * 16'h64 >= 16'(cur_max) * 16'h43);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) blk_cnt_r <= '0;
    else if (i_cur_overrange && one_drive) blk_cnt_r <= blk_cnt_r + 32'h1;
    else blk_cnt_r <= '0;
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) asy_cnt_r <= '0;
    else if (asym_hi && one_drive) asy_cnt_r <= asy_cnt_r + 32'h1;
    else asy_cnt_r <= '0;
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) ovl_cnt_r <= '0;
    else if (o_overload) ovl_cnt_r <= ovl_cnt_r + 32'h1;
    else ovl_cnt_r <= '0;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  property p_nv_we_pulse; o_nv_we |=> !o_nv_we; endproperty
  property p_nv_code_store; o_nv_we |-> (o_nv_code == 4'($past(i_pot) >> 4)); endproperty
  property p_one_dir; !(o_motor_cw && o_motor_ccw); endproperty
  property p_no_drive_off; !i_drive_cw [*6] |-> !o_motor_cw; endproperty
  property p_block_trip; blk_cnt_r > TRIP_LIM |-> !(o_motor_cw || o_motor_ccw); endproperty
  property p_asym_trip; asy_cnt_r > TRIP_LIM |-> !(o_motor_cw || o_motor_ccw); endproperty
  property p_ovld_off; o_overload [*3] |-> !(o_motor_cw || o_motor_ccw); endproperty
  property p_ovld_hold; $fell(o_overload) |-> ovl_cnt_r >= ACK_LIM; endproperty
  property p_msg_on; (i_no_motor && o_motor_cw) [*3] |=> o_message; endproperty
  a_nv_we_pulse: assert property (p_nv_we_pulse) else $error("store pulse too long");
  a_nv_code_store: assert property (p_nv_code_store) else $error("stored step wrong");
  a_one_dir: assert property (p_one_dir) else $error("both directions on");
  a_no_drive_off: assert property (p_no_drive_off) else $error("motor on without drive");
  a_block_trip: assert property (p_block_trip) else $error("blocking not tripped");
  a_asym_trip: assert property (p_asym_trip) else $error("asymmetry not tripped");
  a_ovld_off: assert property (p_ovld_off) else $error("motor on in overload");
  a_ovld_hold: assert property (p_ovld_hold) else $error("overload cleared early");
  a_msg_on: assert property (p_msg_on) else $error("message missing");
  c_block: cover property (blk_cnt_r > TRIP_LIM);
  c_store: cover property (o_nv_we);
  c_msg: cover property ($rose(o_message));
endmodule : mps_properties

bind mps_top mps_properties #(.TICK_CYC(TICK_CYC)) u_props (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_drive_ccw(i_drive_ccw), .i_drive_cw(i_drive_cw),
  .i_cur_l1(i_cur_l1), .i_cur_l3(i_cur_l3), .i_cur_overrange(i_cur_overrange), .i_no_motor(i_no_motor),
  .i_pot(i_pot), .o_nv_we(o_nv_we), .o_nv_code(o_nv_code), .o_motor_ccw(o_motor_ccw),
  .o_motor_cw(o_motor_cw), .o_overload(o_overload), .o_message(o_message));

// [tb/mps_ctl_model.sv]
// controller model: runs the motor on request, stops on overload
`timescale 1ns/1ps
module mps_ctl_model (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // run requests and status bit
  input  wire logic i_run_cw,
  input  wire logic i_run_ccw,
  input  wire logic i_overload,
  // drive commands
  output logic      o_drive_cw,
  output logic      o_drive_ccw
);
  logic inhibit_r;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) inhibit_r <= 1'b0;
    else if (i_overload) inhibit_r <= 1'b1;
    else if (!i_run_cw && !i_run_ccw) inhibit_r <= 1'b0;
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_drive_cw  <= 1'b0;
      o_drive_ccw <= 1'b0;
    end else begin
      o_drive_cw  <= i_run_cw && !inhibit_r && !i_overload;
      o_drive_ccw <= i_run_ccw && !inhibit_r && !i_overload;
    end
  end
endmodule : mps_ctl_model

// [tb/testbench.sv]
// self-checking testbench for the motor protection supervisor
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
  localparam int unsigned TICK = 2;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        btn = 1'b0;
  logic        run_cw = 1'b0;
  logic        run_ccw = 1'b0;
  logic [7:0]  l1 = 8'h20;
  logic [7:0]  l3 = 8'h20;
  logic        ovr = 1'b0;
  logic        nomot = 1'b0;
  logic        phase_miss = 1'b0;
  logic [7:0]  pot = 8'h00;
  logic [3:0]  nv_init = 4'h3;
  logic        drv_cw, drv_ccw, nv_we, m_ccw, m_cw, ovld, msg, l_sup, l_flt, l_ccw, l_cw;
  logic [3:0]  nv_code;
  logic [7:0]  obs;
  logic [7:0]  r;
  logic [15:0] exp_q[$];
  logic [3:0]  nv_q[$];
  logic [15:0] ent;
  int          seed = 51771;
  int          miscompares = 0;
  int          check_count = 0;
  event        chk_ev;
  assign obs = {m_ccw, m_cw, ovld, msg, l_sup, l_flt, l_ccw, l_cw};
  always #25 ref_clk = ~ref_clk;
  mps_ctl_model u_ctl (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_run_cw(run_cw), .i_run_ccw(run_ccw),
    .i_overload(ovld), .o_drive_cw(drv_cw), .o_drive_ccw(drv_ccw));
  mps_top #(.TICK_CYC(TICK)) i_dut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_reset_btn(btn),
    .i_drive_ccw(drv_ccw), .i_drive_cw(drv_cw), .i_cur_l1(l1), .i_cur_l3(l3), .i_cur_overrange(ovr),
    .i_phase_missing(phase_miss), .i_no_motor(nomot), .i_pot(pot), .i_nv_code(nv_init), .o_nv_we(nv_we),
    .o_nv_code(nv_code), .o_motor_ccw(m_ccw), .o_motor_cw(m_cw), .o_overload(ovld), .o_message(msg),
    .o_supply_lamp(l_sup), .o_fault_lamp(l_flt), .o_ccw_lamp(l_ccw), .o_cw_lamp(l_cw));
  // ****
  // tasks
  // ****
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic press(input int ticks);
    @(posedge ref_clk);
    btn <= 1'b1;
    cyc(ticks * TICK);
    btn <= 1'b0;
  endtask : press
  task automatic expect_o(input logic [7:0] e, input logic [7:0] m);
    @(negedge ref_clk);
    exp_q.push_back({m, e});
    -> chk_ev;
    @(posedge ref_clk);
  endtask : expect_o
  task automatic do_reset;
    @(posedge ref_clk);
    rstn <= 1'b0;
    cyc(5);
    expect_o(8'h00, 8'hff);
    cyc(4);
    rstn <= 1'b1;
    cyc(10);
    expect_o(8'h08, 8'hff);
  endtask : do_reset
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // ****
  // result monitors
  // ****
  always begin
    @(chk_ev);
    ent = exp_q.pop_front();
    `CHK(obs & ent[15:8], ent[7:0])
  end
  always @(negedge ref_clk) begin
    if (nv_we === 1'b1) `CHK(nv_code, nv_q.pop_front())
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    end_sim;
  end
  // ****
  // scenarios
  // ****
  initial begin
    do_reset;
    run_cw <= 1'b1;
    nomot <= 1'b1;
    cyc(20);
    expect_o(8'h50, 8'hf0);
    nomot <= 1'b0;
    phase_miss <= 1'b1;
    cyc(5);
    expect_o(8'h50, 8'hf0);
    phase_miss <= 1'b0;
    run_cw <= 1'b0;
    cyc(20);
    r = 8'h10 + (8'($random(seed)) & 8'h1f);
    l1 <= r;
    l3 <= r;
    ovr <= 1'b1;
    run_cw <= 1'b1;
    cyc(1990 * TICK);
    expect_o(8'h40, 8'hf0);
    cyc(30 * TICK);
    expect_o(8'h05, 8'hf7);
    ovr <= 1'b0;
    run_cw <= 1'b0;
    cyc(100);
    expect_o(8'h04, 8'hc4);
    press(20);
    cyc(20);
    expect_o(8'h08, 8'hff);
    l1 <= 8'h3c;
    l3 <= 8'h10;
    run_ccw <= 1'b1;
    cyc(1990 * TICK);
    expect_o(8'h80, 8'hf0);
    cyc(30 * TICK);
    expect_o(8'h06, 8'hf7);
    run_ccw <= 1'b0;
    cyc(100);
    expect_o(8'h04, 8'hc4);
    press(20);
    cyc(20);
    expect_o(8'h08, 8'hff);
    press(50);
    cyc(20);
    expect_o(8'h08, 8'hff);
    pot <= {1'b0, 7'($random(seed))};
    press(6010);
    cyc(50 * TICK);
    expect_o(8'h08, 8'h0f);
    cyc(940 * TICK);
    expect_o({5'h00, pot[6:4]}, 8'h0f);
    cyc(1450 * TICK);
    expect_o(8'h00, 8'h0f);
    nv_q.push_back(pot[7:4]);
    press(20);
    cyc(20);
    expect_o(8'h08, 8'hff);
    `CHK(nv_q.size(), 0)
    press(2500);
    cyc(10);
    expect_o({5'h00, pot[6:4]}, 8'hff);
    cyc(2950 * TICK);
    expect_o({5'h00, pot[6:4]}, 8'h0f);
    cyc(80 * TICK);
    expect_o(8'h08, 8'hff);
    l1 <= 8'h00;
    l3 <= 8'h00;
    run_cw <= 1'b1;
    cyc(20);
    press(2500);
    cyc(20 * TICK);
    expect_o(8'h58, 8'hd8);
    l1 <= 8'hf0;
    l3 <= 8'hf0;
    cyc(20);
    expect_o(8'h20, 8'he0);
    `CHK(drv_cw, 1'b0)
    run_cw <= 1'b0;
    do_reset;
    end_sim;
  end
endmodule : testbench
